/* File: include/tmr_consts.svh */
// pointer codes, reset values and field positions of the register file
// What this block does
// RQ1: eight-bit pointer picks the responding data register
// RQ2: first write byte reloads pointer; pointer then held
// RQ3: master writes pointer before reading wanted register
// RQ4: pointer resets to zero, reads local high
// RQ5: separate read/write codes; rate resets to 08
// RQ6: read-only result bytes, low nibbles in 7:4
// RQ7: local high/low limits read-write, reset 7f/80
// RQ8: remote high limit byte plus nibble, reset f0
// RQ9: remote low limit byte plus nibble
// RQ10: twelve-bit remote offset, high byte, low nibble
// RQ11: critical limits at 19 and 20, reset 7f
// RQ12: two-bit filter setting at 24, rest zero
// RQ13: any write to 0f starts one conversion
// RQ14: read-only status at 02, flags per bit
// RQ15: configuration write 09 read 03, four bits
// RQ16: reserved bits read zero, writes ignored; bit 0 at 22 reads one
// RQ17: unassigned pointer reads as zero
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// read pointer codes
`define TMR_RD_LRH   8'h00
`define TMR_RD_RRH   8'h01
`define TMR_RD_STAT  8'h02
`define TMR_RD_CFG   8'h03
`define TMR_RD_RATE  8'h04
`define TMR_RD_LHL   8'h05
`define TMR_RD_LLL   8'h06
`define TMR_RD_RHLH  8'h07
`define TMR_RD_RLLH  8'h08
`define TMR_RD_RRL   8'h10
`define TMR_RD_LRL   8'h15
`define TMR_RD_ID    8'hfe
// write pointer codes that differ from the read codes
`define TMR_WR_CFG   8'h09
`define TMR_WR_RATE  8'h0a
`define TMR_WR_LHL   8'h0b
`define TMR_WR_LLL   8'h0c
`define TMR_WR_RHLH  8'h0d
`define TMR_WR_RLLH  8'h0e
`define TMR_WR_SHOT  8'h0f
// codes shared by read and write
`define TMR_RW_OFSH  8'h11
`define TMR_RW_OFSL  8'h12
`define TMR_RW_RHLL  8'h13
`define TMR_RW_RLLL  8'h14
`define TMR_RW_CHEN  8'h16
`define TMR_RW_RCRIT 8'h19
`define TMR_RW_LCRIT 8'h20
`define TMR_RW_HYS   8'h21
`define TMR_RW_CONAL 8'h22
`define TMR_RW_NC    8'h23
`define TMR_RW_FILT  8'h24

// reset values
`define TMR_RST_PTR   8'h00
`define TMR_RST_BYTE  8'h00
`define TMR_RST_NIB   4'h0
`define TMR_RST_RES   12'h000
`define TMR_RST_CFG   4'h0
`define TMR_RST_RATE  4'h8
`define TMR_RST_HIGH  8'h7f
`define TMR_RST_LOW   8'h80
`define TMR_RST_RHLL  4'hf
`define TMR_RST_CHEN  2'h3
`define TMR_RST_CRIT  8'h7f
`define TMR_RST_HYS   8'h0a
`define TMR_RST_CONAL 3'h0
`define TMR_RST_FILT  2'h0

// configuration field positions within the written byte
`define TMR_CFG_MASK  7
`define TMR_CFG_SD    6
`define TMR_CFG_SEL   5
`define TMR_CFG_RANGE 2

`endif

/* File: include/tmr_pkg.sv */
// types of the temperature monitor register file
package tmr_pkg;

   // whole state of the register file
   typedef struct packed {
      logic [7:0]  ptr;
      logic        ptr_pend;
      logic [3:0]  cfg;       // mask, shutdown, pin select, range
      logic [3:0]  rate;
      logic [7:0]  lhl;
      logic [7:0]  lll;
      logic [7:0]  rhl_h;
      logic [3:0]  rhl_l;
      logic [7:0]  rll_h;
      logic [3:0]  rll_l;
      logic [7:0]  ofs_h;
      logic [3:0]  ofs_l;
      logic [1:0]  chen;
      logic [7:0]  rcrit;
      logic [7:0]  lcrit;
      logic [7:0]  hys;
      logic [2:0]  conal;
      logic [7:0]  nc;
      logic [1:0]  filt;
      logic [11:0] lt;
      logic [11:0] rt;
      logic [7:0]  rd_data;
      logic        rd_valid;
      logic        one_shot;
      logic        status_rd;
   } tmr_state_t;

endpackage

/* File: src/tmr_rd_mux.sv */
// read data selection by pointer
`timescale 1ns/1ps
`include "tmr_consts.svh"

module tmr_rd_mux #(
   parameter logic [7:0] ID_CODE = 8'ha3  // arbitrary identification value
) (
   // selection
   input  wire logic [7:0]          ptr,
   // register contents
   input  wire tmr_pkg::tmr_state_t s,
   input  wire logic [7:0]          status_byte,
   // result
   output logic [7:0]               data
);
   import tmr_pkg::*;

   // a nibble field sits in bits 7:4, the rest reads zero
   function automatic logic [7:0] hi_nib(input logic [3:0] n);
      return {n, 4'h0};
   endfunction

   // unassigned codes and write-only codes fall to zero
   always_comb begin
      case (ptr)
         `TMR_RD_LRH:   data = s.lt[11:4];                    // RQ4
         `TMR_RD_RRH:   data = s.rt[11:4];                    // RQ6
         `TMR_RD_STAT:  data = status_byte;                   // RQ14
         `TMR_RD_CFG:   data = {s.cfg[3:1], 2'h0, s.cfg[0], 2'h0}; // RQ15
         `TMR_RD_RATE:  data = {4'h0, s.rate};                // RQ5
         `TMR_RD_LHL:   data = s.lhl;                         // RQ7
         `TMR_RD_LLL:   data = s.lll;
         `TMR_RD_RHLH:  data = s.rhl_h;                       // RQ8
         `TMR_RD_RLLH:  data = s.rll_h;                       // RQ9
         `TMR_RD_RRL:   data = hi_nib(s.rt[3:0]);             // RQ6
         `TMR_RD_LRL:   data = hi_nib(s.lt[3:0]);
         `TMR_RW_OFSH:  data = s.ofs_h;                       // RQ10
         `TMR_RW_OFSL:  data = hi_nib(s.ofs_l);
         `TMR_RW_RHLL:  data = hi_nib(s.rhl_l);               // RQ8
         `TMR_RW_RLLL:  data = hi_nib(s.rll_l);               // RQ9
         `TMR_RW_CHEN:  data = {6'h00, s.chen};               // RQ16
         `TMR_RW_RCRIT: data = s.rcrit;                       // RQ11
         `TMR_RW_LCRIT: data = s.lcrit;
         `TMR_RW_HYS:   data = s.hys;
         `TMR_RW_CONAL: data = {4'h0, s.conal, 1'b1};
         `TMR_RW_NC:    data = s.nc;
         `TMR_RW_FILT:  data = {6'h00, s.filt};               // RQ12
         `TMR_RD_ID:    data = ID_CODE;
         default:       data = 8'h00;                         // RQ17
      endcase
   end
endmodule

/* File: src/tmr_regfile.sv */
// pointer-addressed register file of the dual-channel temperature monitor
`timescale 1ns/1ps
`include "tmr_consts.svh"

module tmr_regfile #(
   parameter logic [7:0] ID_CODE = 8'ha3  // arbitrary identification value
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // byte stream from the serial protocol engine
   input  wire logic        wr_begin,
   input  wire logic        wr_valid,
   input  wire logic [7:0]  wr_byte,
   input  wire logic        rd_req,
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   // measurement results
   input  wire logic        result_valid,
   input  wire logic [11:0] new_local_result,
   input  wire logic [11:0] new_remote_result,
   // condition inputs shown in the status byte
   input  wire logic        conv_busy,
   input  wire logic        local_over_limit_flag,
   input  wire logic        local_under_limit_flag,
   input  wire logic        remote_over_limit_flag,
   input  wire logic        remote_under_limit_flag,
   input  wire logic        remote_open,
   input  wire logic        remote_critical_flag,
   input  wire logic        local_critical_flag,
   // pulses to the conversion and alert logic
   output logic             one_shot_start,
   output logic             status_read,
   // configuration
   output logic             alert_suppress,
   output logic             shutdown_request,
   output logic             alert_pin_function_select,
   output logic             extended_range,
   output logic [3:0]       conversion_rate_code,
   output logic             local_channel_on,
   output logic             remote_channel_on,
   output logic [1:0]       filter_depth_select,
   output logic [2:0]       alert_count_setting,
   output logic [7:0]       ideality_correction,
   // limits, correction and pointer
   output logic [7:0]       local_high_limit_bits,
   output logic [7:0]       local_low_limit_bits,
   output logic [11:0]      remote_high_limit_bits,
   output logic [11:0]      remote_low_limit_bits,
   output logic [11:0]      remote_correction_value,
   output logic [7:0]       remote_critical_limit_bits,
   output logic [7:0]       local_critical_limit_bits,
   output logic [7:0]       critical_release_margin,
   output logic [7:0]       pointer
);
   import tmr_pkg::*;

   tmr_state_t s_reg;
   tmr_state_t s_next;
   logic [7:0] status_byte;
   logic [7:0] mux_byte;
   logic       data_wr;

   // status is live: the alert logic owns the sticky behaviour
   assign status_byte = {conv_busy, local_over_limit_flag, local_under_limit_flag,
                         remote_over_limit_flag, remote_under_limit_flag, remote_open,
                         remote_critical_flag, local_critical_flag};

   // a byte that lands at the pointer, not a pointer byte
   assign data_wr = wr_valid && !wr_begin && !s_reg.ptr_pend;

   // read data for the current pointer
   tmr_rd_mux #(
      .ID_CODE     (ID_CODE)
   ) u_rd_mux (
      .ptr         (s_reg.ptr),
      .s           (s_reg),
      .status_byte (status_byte),
      .data        (mux_byte)
   );

   // next state: pointer load, register writes, reads, results
   always_comb begin
      s_next = s_reg;
      s_next.rd_valid  = 1'b0;
      s_next.one_shot  = 1'b0;
      s_next.status_rd = 1'b0;
      // results land whenever a conversion completes
      if (result_valid) begin
         s_next.lt = new_local_result;
         s_next.rt = new_remote_result;
      end
      // a new write transaction always expects a pointer byte first
      if (wr_begin) begin
         s_next.ptr_pend = 1'b1;                              // RQ2
      end else if (wr_valid && s_reg.ptr_pend) begin
         s_next.ptr      = wr_byte;                           // RQ1
         s_next.ptr_pend = 1'b0;                              // RQ2
      end else if (wr_valid) begin
         // data bytes; codes without a write function are ignored
         case (s_reg.ptr)
            `TMR_WR_CFG:   s_next.cfg = {wr_byte[`TMR_CFG_MASK], wr_byte[`TMR_CFG_SD],
                                         wr_byte[`TMR_CFG_SEL], wr_byte[`TMR_CFG_RANGE]}; // RQ15
            `TMR_WR_RATE:  s_next.rate  = wr_byte[3:0];       // RQ5
            `TMR_WR_LHL:   s_next.lhl   = wr_byte;            // RQ7
            `TMR_WR_LLL:   s_next.lll   = wr_byte;            // RQ7
            `TMR_WR_RHLH:  s_next.rhl_h = wr_byte;            // RQ8
            `TMR_WR_RLLH:  s_next.rll_h = wr_byte;            // RQ9
            `TMR_WR_SHOT:  s_next.one_shot = 1'b1;            // RQ13
            `TMR_RW_OFSH:  s_next.ofs_h = wr_byte;            // RQ10
            `TMR_RW_OFSL:  s_next.ofs_l = wr_byte[7:4];       // RQ10
            `TMR_RW_RHLL:  s_next.rhl_l = wr_byte[7:4];       // RQ8
            `TMR_RW_RLLL:  s_next.rll_l = wr_byte[7:4];       // RQ9
            `TMR_RW_CHEN:  s_next.chen  = wr_byte[1:0];       // RQ16
            `TMR_RW_RCRIT: s_next.rcrit = wr_byte;            // RQ11
            `TMR_RW_LCRIT: s_next.lcrit = wr_byte;            // RQ11
            `TMR_RW_HYS:   s_next.hys   = wr_byte;
            `TMR_RW_CONAL: s_next.conal = wr_byte[3:1];
            `TMR_RW_NC:    s_next.nc    = wr_byte;
            `TMR_RW_FILT:  s_next.filt  = wr_byte[1:0];       // RQ12
            default:       s_next.ptr_pend = 1'b0;            // RQ16
         endcase
      end
      // one byte returned per read request, pointer left as is
      if (rd_req) begin
         s_next.rd_data  = mux_byte;                          // RQ1
         s_next.rd_valid = 1'b1;
         // tell the alert logic so it may clear its sticky flags
         if (s_reg.ptr == `TMR_RD_STAT) begin
            s_next.status_rd = 1'b1;                          // RQ14
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg.ptr       <= `TMR_RST_PTR;                     // RQ4
         s_reg.ptr_pend  <= 1'b0;
         s_reg.cfg       <= `TMR_RST_CFG;
         s_reg.rate      <= `TMR_RST_RATE;                    // RQ5
         s_reg.lhl       <= `TMR_RST_HIGH;                    // RQ7
         s_reg.lll       <= `TMR_RST_LOW;
         s_reg.rhl_h     <= `TMR_RST_HIGH;                    // RQ8
         s_reg.rhl_l     <= `TMR_RST_RHLL;
         s_reg.rll_h     <= `TMR_RST_LOW;                     // RQ9
         s_reg.rll_l     <= `TMR_RST_NIB;
         s_reg.ofs_h     <= `TMR_RST_BYTE;                    // RQ10
         s_reg.ofs_l     <= `TMR_RST_NIB;
         s_reg.chen      <= `TMR_RST_CHEN;
         s_reg.rcrit     <= `TMR_RST_CRIT;                    // RQ11
         s_reg.lcrit     <= `TMR_RST_CRIT;
         s_reg.hys       <= `TMR_RST_HYS;
         s_reg.conal     <= `TMR_RST_CONAL;
         s_reg.nc        <= `TMR_RST_BYTE;
         s_reg.filt      <= `TMR_RST_FILT;                    // RQ12
         s_reg.lt        <= `TMR_RST_RES;                     // RQ6
         s_reg.rt        <= `TMR_RST_RES;
         s_reg.rd_data   <= `TMR_RST_BYTE;
         s_reg.rd_valid  <= 1'b0;
         s_reg.one_shot  <= 1'b0;
         s_reg.status_rd <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state flops
   assign rd_data                    = s_reg.rd_data;
   assign rd_valid                   = s_reg.rd_valid;
   assign one_shot_start             = s_reg.one_shot;
   assign status_read                = s_reg.status_rd;
   assign alert_suppress             = s_reg.cfg[3];
   assign shutdown_request           = s_reg.cfg[2];
   assign alert_pin_function_select  = s_reg.cfg[1];
   assign extended_range             = s_reg.cfg[0];
   assign conversion_rate_code       = s_reg.rate;
   assign local_channel_on           = s_reg.chen[0];
   assign remote_channel_on          = s_reg.chen[1];
   assign filter_depth_select        = s_reg.filt;
   assign alert_count_setting        = s_reg.conal;
   assign ideality_correction        = s_reg.nc;
   assign local_high_limit_bits      = s_reg.lhl;
   assign local_low_limit_bits       = s_reg.lll;
   assign remote_high_limit_bits     = {s_reg.rhl_h, s_reg.rhl_l};
   assign remote_low_limit_bits      = {s_reg.rll_h, s_reg.rll_l};
   assign remote_correction_value    = {s_reg.ofs_h, s_reg.ofs_l};
   assign remote_critical_limit_bits = s_reg.rcrit;
   assign local_critical_limit_bits  = s_reg.lcrit;
   assign critical_release_margin    = s_reg.hys;
   assign pointer                    = s_reg.ptr;

   // pointer byte lands in the pointer
   property p_ptr_load;
      @(posedge clk) disable iff (rst)
      (wr_valid && !wr_begin && s_reg.ptr_pend) |=> (pointer == $past(wr_byte));
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // RQ2

   // pointer holds across reads and data bytes
   property p_ptr_hold;
      @(posedge clk) disable iff (rst)
      !(wr_valid && s_reg.ptr_pend) |=> $stable(pointer);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved"); // RQ2

   // a read answers the next cycle with the selected register
   property p_rd_sel;
      @(posedge clk) disable iff (rst)
      (rd_req && pointer == `TMR_RD_LHL) |=> (rd_valid && rd_data == $past(s_reg.lhl));
   endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("wrong register read"); // RQ1

   // pointer zero returns the local result high byte
   property p_rd_zero;
      @(posedge clk) disable iff (rst)
      (rd_req && pointer == `TMR_RD_LRH) |=> (rd_data == $past(s_reg.lt[11:4]));
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("pointer zero read wrong"); // RQ4

   // rate written at its own write code
   property p_rate_wr;
      @(posedge clk) disable iff (rst)
      (wr_valid && !wr_begin && !s_reg.ptr_pend && pointer == `TMR_WR_RATE)
         |=> (conversion_rate_code == $past(wr_byte[3:0]));
   endproperty
   a_rate_wr: assert property (p_rate_wr) else $error("rate not written"); // RQ5

   // result registers are not writable
   property p_res_ro;
      @(posedge clk) disable iff (rst)
      (wr_valid && !s_reg.ptr_pend && !result_valid && pointer == `TMR_RD_LRH)
         |=> $stable(s_reg.lt);
   endproperty
   a_res_ro: assert property (p_res_ro) else $error("result overwritten"); // RQ6

   // local high limit written at 0b
   property p_lhl_wr;
      @(posedge clk) disable iff (rst)
      (wr_valid && !wr_begin && !s_reg.ptr_pend && pointer == `TMR_WR_LHL)
         |=> (local_high_limit_bits == $past(wr_byte));
   endproperty
   a_lhl_wr: assert property (p_lhl_wr) else $error("local high limit not written"); // RQ7

   // low nibble registers read zero in bits 3:0
   property p_nib_rd;
      @(posedge clk) disable iff (rst)
      (rd_req && (pointer == `TMR_RW_RHLL || pointer == `TMR_RW_OFSL))
         |=> (rd_data[3:0] == 4'h0);
   endproperty
   a_nib_rd: assert property (p_nib_rd) else $error("nibble register low bits set"); // RQ8

   // critical limit write at the shared code
   property p_crit_wr;
      @(posedge clk) disable iff (rst)
      (wr_valid && !wr_begin && !s_reg.ptr_pend && pointer == `TMR_RW_LCRIT)
         |=> (local_critical_limit_bits == $past(wr_byte));
   endproperty
   a_crit_wr: assert property (p_crit_wr) else $error("critical limit not written"); // RQ11

   // filter register upper bits read zero
   property p_filt_rd;
      @(posedge clk) disable iff (rst)
      (rd_req && pointer == `TMR_RW_FILT) |=> (rd_data[7:2] == 6'h00);
   endproperty
   a_filt_rd: assert property (p_filt_rd) else $error("filter upper bits set"); // RQ12

   // one-shot pulse follows a data write to 0f
   property p_shot;
      @(posedge clk) disable iff (rst)
      (wr_valid && !wr_begin && !s_reg.ptr_pend && pointer == `TMR_WR_SHOT)
         |=> (one_shot_start ##1 !one_shot_start);
   endproperty
   a_shot: assert property (p_shot) else $error("one-shot pulse missing"); // RQ13

   // status read is flagged together with its data
   property p_stat_rd;
      @(posedge clk) disable iff (rst)
      (rd_req && pointer == `TMR_RD_STAT) |=> (status_read && rd_data == $past(status_byte));
   endproperty
   a_stat_rd: assert property (p_stat_rd) else $error("status read wrong"); // RQ14

   // configuration reserved bits read zero
   property p_cfg_rd;
      @(posedge clk) disable iff (rst)
      (rd_req && pointer == `TMR_RD_CFG) |=> (rd_data[4:3] == 2'h0 && rd_data[1:0] == 2'h0);
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config reserved bits set"); // RQ15

   // write-only pointer 0f reads zero
   property p_unmapped;
      @(posedge clk) disable iff (rst)
      (rd_req && pointer == `TMR_WR_SHOT) |=> (rd_data == 8'h00);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // RQ17

   // remote low limit high byte lands at 0e
   property p_rll_wr;
      @(posedge clk) disable iff (rst)
      (data_wr && pointer == `TMR_WR_RLLH)
         |=> (remote_low_limit_bits[11:4] == $past(wr_byte));
   endproperty
   a_rll_wr: assert property (p_rll_wr) else $error("remote low not written"); // RQ9

   // offset low nibble from bits 7:4
   property p_ofs_wr;
      @(posedge clk) disable iff (rst)
      (data_wr && pointer == `TMR_RW_OFSL)
         |=> (remote_correction_value[3:0] == $past(wr_byte[7:4]));
   endproperty
   a_ofs_wr: assert property (p_ofs_wr) else $error("offset not written"); // RQ10

   // filter takes bits 1:0
   property p_filt_wr;
      @(posedge clk) disable iff (rst)
      (data_wr && pointer == `TMR_RW_FILT)
         |=> (filter_depth_select == $past(wr_byte[1:0]));
   endproperty
   a_filt_wr: assert property (p_filt_wr) else $error("filter not written"); // RQ12

   // no start pulse without a data byte at 0f
   property p_no_shot;
      @(posedge clk) disable iff (rst)
      !(data_wr && pointer == `TMR_WR_SHOT)
         |=> !one_shot_start;
   endproperty
   a_no_shot: assert property (p_no_shot) else $error("spurious one-shot"); // RQ13

   // configuration bits taken at 09
   property p_cfg_wr;
      @(posedge clk) disable iff (rst)
      (data_wr && pointer == `TMR_WR_CFG) |=> (extended_range == $past(wr_byte[`TMR_CFG_RANGE])
         && alert_suppress == $past(wr_byte[`TMR_CFG_MASK]));
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("config not written"); // RQ15

   // a read code takes no data
   property p_ro_wr;
      @(posedge clk) disable iff (rst)
      (data_wr && pointer == `TMR_RD_CFG)
         |=> $stable(s_reg.cfg);
   endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("read code took data"); // RQ16

endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the temperature monitor register file
`timescale 1ns/1ps

module tb_top;
   localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identification value

   logic        clk, rst, wr_begin, wr_valid, rd_req, rd_valid, result_valid;
   logic [7:0]  wr_byte, rd_data, flags, pointer, lhl, llb, rcl, lcl, crm, nc;
   logic [11:0] new_local_result, new_remote_result, rhl, rll, ofs;
   logic        one_shot_start, status_read;
   logic [3:0]  rate;
   logic [2:0]  conal;
   logic [1:0]  filt;
   wire  [3:0]  cfg_bits;
   wire  [1:0]  chen;
   int          error_cnt = 0;
   int          checked = 0;
   int          shot_cnt = 0;

   tmr_regfile #(.ID_CODE(ID_VAL)) i_dut (
      .clk(clk), .rst(rst), .wr_begin(wr_begin), .wr_valid(wr_valid), .wr_byte(wr_byte),
      .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid), .result_valid(result_valid),
      .new_local_result(new_local_result), .new_remote_result(new_remote_result),
      .conv_busy(flags[7]), .local_over_limit_flag(flags[6]),
      .local_under_limit_flag(flags[5]), .remote_over_limit_flag(flags[4]),
      .remote_under_limit_flag(flags[3]), .remote_open(flags[2]),
      .remote_critical_flag(flags[1]), .local_critical_flag(flags[0]),
      .one_shot_start(one_shot_start), .status_read(status_read),
      .alert_suppress(cfg_bits[3]), .shutdown_request(cfg_bits[2]),
      .alert_pin_function_select(cfg_bits[1]), .extended_range(cfg_bits[0]),
      .conversion_rate_code(rate), .local_channel_on(chen[0]), .remote_channel_on(chen[1]),
      .filter_depth_select(filt), .alert_count_setting(conal), .ideality_correction(nc),
      .local_high_limit_bits(lhl), .local_low_limit_bits(llb), .remote_high_limit_bits(rhl),
      .remote_low_limit_bits(rll), .remote_correction_value(ofs),
      .remote_critical_limit_bits(rcl), .local_critical_limit_bits(lcl),
      .critical_release_margin(crm), .pointer(pointer)
   );

   tmr_host_model i_host (
      .clk(clk), .rst(rst), .wr_begin(wr_begin), .wr_valid(wr_valid), .wr_byte(wr_byte),
      .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid)
   );

   // clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // watch pulses; a stretched pulse counts more than once
   always @(posedge clk) begin
      if (one_shot_start === 1'b1) shot_cnt++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (error_cnt == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // read with latency check; a missing answer ends the run
   task automatic rd(input bit set_p, input logic [7:0] p, output logic [7:0] v);
      int lat;
      i_host.read(set_p, p, v, lat);
      chk(lat, 1);
      if (lat >= 8) begin
         error_cnt++;
         complete_run();
      end
   endtask

   // reset values, unassigned and write-only codes: {read code, value}
   logic [15:0] rtab [28] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h0408, 16'h057f,
      16'h0680, 16'h077f, 16'h0880, 16'h1000, 16'h1100, 16'h1200, 16'h13f0, 16'h1400,
      16'h1500, 16'h1603, 16'h197f, 16'h207f, 16'h210a, 16'h2201, 16'h2300, 16'h2400,
      {8'hfe, ID_VAL}, 16'h0900, 16'h0a00, 16'h0f00, 16'h1700, 16'hff00};
   // {write code, read code, data, expected}; last rows hit read-only codes
   logic [31:0] wtab [21] = '{32'h0903ffe4, 32'h0a04ff0f, 32'h0b055a5a, 32'h0c06a5a5,
      32'h0d071212, 32'h13133c30, 32'h0e083434, 32'h1414fff0, 32'h1111c3c3, 32'h1212fff0,
      32'h19191111, 32'h20202222, 32'h2424ff03, 32'h1616fe02, 32'h2222ff0f, 32'h21219999,
      32'h23237777, 32'h030300e4, 32'h0505005a, 32'h0000ff00, {16'hfefe, 8'h00, ID_VAL}};
   logic [15:0] res_tab [4] = '{16'h001a, 16'h1530, 16'h01fe, 16'h1070};

   initial begin
      logic [7:0] v;
      rst = 1'b1;
      result_valid = 1'b0;
      new_local_result = 12'h000;
      new_remote_result = 12'h000;
      flags = 8'h00;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(1'b0, 8'h00, v);
      chk(v, 8'h00);
      for (int i = 0; i < 28; i++) begin
         rd(1'b1, rtab[i][15:8], v);
         chk(v, rtab[i][7:0]);
      end
      // every second write leaves a gap before its data byte
      for (int i = 0; i < 21; i++) begin
         i_host.write(wtab[i][31:24], wtab[i][15:8], 1'b1, i[0]);
         rd(1'b1, wtab[i][23:16], v);
         chk(v, wtab[i][7:0]);
      end
      chk({cfg_bits, rate}, 8'hff);
      chk({rhl, rll}, 24'h12334f);
      chk(ofs, 12'hc3f);
      chk({llb, rcl, lcl, crm}, 32'ha5112299);
      chk({chen, filt, conal, nc}, 15'h5f77);
      // held pointer, then reloaded by a data write
      i_host.write(8'h05, 8'h00, 1'b0, 1'b0);
      rd(1'b0, 8'h00, v);
      rd(1'b0, 8'h00, v);
      chk({pointer, v}, 16'h055a);
      i_host.write(8'h0b, 8'h66, 1'b1, 1'b0);
      rd(1'b0, 8'h00, v);
      chk({pointer, v, lhl}, 24'h0b0066);
      // new results
      @(posedge clk);
      result_valid <= 1'b1;
      new_local_result <= 12'h1a3;
      new_remote_result <= 12'hfe7;
      @(posedge clk);
      result_valid <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(1'b1, res_tab[i][15:8], v);
         chk(v, res_tab[i][7:0]);
      end
      // status bits and their read pulse
      flags <= 8'hc6;
      rd(1'b1, 8'h02, v);
      chk({v, 7'h00, status_read}, 16'hc601);
      flags <= 8'h39;
      rd(1'b0, 8'h00, v);
      chk(v, 8'h39);
      rd(1'b1, 8'h00, v);
      chk(status_read, 1'b0);
      // one-shot trigger; a pointer-only write must not start it
      i_host.write(8'h0f, 8'h00, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      chk(shot_cnt, 0);
      i_host.write(8'h0f, 8'h5c, 1'b1, 1'b0);
      repeat (3) @(posedge clk);
      chk(shot_cnt, 1);
      i_host.write(8'h0f, 8'h00, 1'b1, 1'b1);
      repeat (3) @(posedge clk);
      chk(shot_cnt, 2);
      // second reset in mid-run
      i_host.write(8'h05, 8'h00, 1'b0, 1'b0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(1'b0, 8'h00, v);
      chk({pointer, v}, 16'h0000);
      rd(1'b1, 8'h05, v);
      chk({v, lhl}, 16'h7f7f);
      complete_run();
   end
endmodule

/* File: tb/tmr_host_model.sv */
// bus master model driving the register file byte stream
`timescale 1ns/1ps

module tmr_host_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // byte stream toward the device
   output logic            wr_begin,
   output logic            wr_valid,
   output logic [7:0]      wr_byte,
   output logic            rd_req,
   // answer from the device
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid
);
   // idle lines at time zero
   initial begin
      wr_begin = 1'b0;
      wr_valid = 1'b0;
      wr_byte  = 8'h00;
      rd_req   = 1'b0;
   end

   // start, pointer byte, optional data byte; slow leaves a gap before the data
   task automatic write(input logic [7:0] p, input logic [7:0] d, input bit has_d,
                        input bit slow);
      @(posedge clk);
      wr_begin <= 1'b1;
      @(posedge clk);
      wr_begin <= 1'b0;
      wr_valid <= 1'b1;
      wr_byte  <= p;
      if (has_d) begin
         if (slow) begin
            @(posedge clk);
            wr_valid <= 1'b0;
            wr_byte  <= ~p;
         end
         @(posedge clk);
         wr_valid <= 1'b1;
         wr_byte  <= d;
      end
      @(posedge clk);
      wr_valid <= 1'b0;
      // released byte shows the inverse so a stale value is never mistaken for data
      wr_byte  <= has_d ? ~d : ~p;
   endtask

   // one byte read; lat counts edges until the answer, capped at 8
   task automatic read(input bit set_p, input logic [7:0] p, output logic [7:0] v,
                       output int lat);
      if (set_p) write(p, 8'h00, 1'b0, 1'b0);
      @(posedge clk);
      rd_req <= 1'b1;
      @(posedge clk);
      rd_req <= 1'b0;
      lat = 0;
      v   = 'x;
      while (lat < 8) begin
         lat++;
         @(posedge clk);
         if (rd_valid === 1'b1) begin
            v = rd_data;
            break;
         end
      end
   endtask
endmodule
